// ==== dio_function_mapper.sv ====
/*
 * Digital I/O function mapper: maps input pins onto input functions and
 * output functions onto output pins, with polarity, display, execution and
 * output masks, all reached through an index/sub-index parameter port.
 * Assumes input pins are asynchronous and that the parameter port and the
 * motion core signals run on clk.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_function_mapper #(
  parameter int N_IN = 10,
  parameter int N_OUT = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] par_index,
  input wire logic [7:0] par_subindex,
  input wire logic par_write,
  input wire logic par_read,
  input wire logic [15:0] par_wdata,
  output var logic [15:0] par_rdata,
  output var logic par_ack,
  output var logic par_error,
  input wire logic [N_IN-1:0] input_pin,
  output logic [N_OUT-1:0] output_pin,
  input wire logic brake_engage,
  input wire logic compare_trigger,
  input wire logic device_ready,
  input wire logic device_fault,
  output var logic quick_stop,
  output var logic device_enable,
  output var logic position_marker,
  output var logic home_switch,
  output var logic pos_limit,
  output var logic neg_limit,
  output var logic limit_error
);

  localparam int SW = dio_pkg::SEL_W;

  // ****************************************************************
  // Registers and internal signals
  // ****************************************************************
  logic [15:0] in_cfg_q [N_IN];
  logic [15:0] out_cfg_q [N_OUT];
  logic [15:0] in_disp_q;
  logic [15:0] in_pol_q;
  logic [15:0] in_exec_q;
  logic [15:0] out_state_q;
  logic [15:0] out_mask_q;
  logic [15:0] out_pol_q;
  logic [15:0] applied_q;
  logic [15:0] in_func_d;
  logic [15:0] in_func_q;
  logic [15:0] in_func_prev_q;
  logic [15:0] out_func_d;
  logic [N_IN-1:0] in_sync;
  logic [15:0] rd_data_d;
  logic hit_d;
  logic ro_d;
  logic wr_ok;
  logic rd_state_q;

  // ****************************************************************
  // Input pin path
  // ****************************************************************

  // Pins are asynchronous to clk, so each passes two flops first.
  dio_sync2 #(.W(N_IN)) u_in_sync (
    .clk(clk),
    .reset(reset),
    .d(input_pin),
    .q(in_sync)
  );

  // Each pin sets the bit its config selects, after polarity; several pins on one bit are ORed.
  always_comb begin
    in_func_d = '0;
    for (int k = 0; k < N_IN; k++) begin
      in_func_d[in_cfg_q[k][SW-1:0]] = in_func_d[in_cfg_q[k][SW-1:0]]
        | (in_sync[k] ^ in_pol_q[in_cfg_q[k][SW-1:0]]);
    end
  end

  // The state word is registered so that reads and actions see one value.
  always_ff @(posedge clk) begin
    if (reset) begin
      in_func_q <= '0;
      in_func_prev_q <= '0;
    end else begin
      in_func_q <= in_func_d;
      in_func_prev_q <= in_func_q;
    end
  end

  // Actions: each function drives its own action only where execution is allowed.
  always_ff @(posedge clk) begin
    if (reset) begin
      quick_stop <= 1'b0;
      device_enable <= 1'b0;
      home_switch <= 1'b0;
      pos_limit <= 1'b0;
      neg_limit <= 1'b0;
      limit_error <= 1'b0;
    end else begin
      quick_stop <= in_func_q[dio_pkg::IN_QSTOP] & in_exec_q[dio_pkg::IN_QSTOP];
      device_enable <= in_func_q[dio_pkg::IN_ENABLE] & in_exec_q[dio_pkg::IN_ENABLE];
      home_switch <= in_func_q[dio_pkg::IN_HOME] & in_exec_q[dio_pkg::IN_HOME];
      pos_limit <= in_func_q[dio_pkg::IN_POS_LIMIT] & in_exec_q[dio_pkg::IN_POS_LIMIT];
      neg_limit <= in_func_q[dio_pkg::IN_NEG_LIMIT] & in_exec_q[dio_pkg::IN_NEG_LIMIT];
      limit_error <= (in_func_q[dio_pkg::IN_POS_LIMIT] & in_exec_q[dio_pkg::IN_POS_LIMIT])
        | (in_func_q[dio_pkg::IN_NEG_LIMIT] & in_exec_q[dio_pkg::IN_NEG_LIMIT]);
    end
  end

  // Position marker is a one-cycle pulse on the rising edge of its function.
  always_ff @(posedge clk) begin
    if (reset) begin
      position_marker <= 1'b0;
    end else begin
      position_marker <= in_func_q[dio_pkg::IN_MARKER] & ~in_func_prev_q[dio_pkg::IN_MARKER]
        & in_exec_q[dio_pkg::IN_MARKER];
    end
  end

  // ****************************************************************
  // Output function path
  // ****************************************************************

  // General-purpose bits come from software, the low bits from the motion core.
  always_comb begin
    out_func_d = out_state_q & dio_pkg::OUT_GP_BITS;
    out_func_d[dio_pkg::OUT_BRAKE] = brake_engage;
    out_func_d[dio_pkg::OUT_PCMP] = compare_trigger;
    out_func_d[dio_pkg::OUT_READY] = device_ready & ~device_fault;
  end

  // A masked-off bit holds its last applied value, so changes do not reach the pin.
  always_ff @(posedge clk) begin
    if (reset) begin
      applied_q <= '0;
    end else begin
      applied_q <= (applied_q & ~out_mask_q) | (out_func_d & out_mask_q);
    end
  end

  // One mapper per pin; all share the masked word and the polarity word.
  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    dio_out_map u_map (
      .clk(clk),
      .reset(reset),
      .sel(out_cfg_q[g][SW-1:0]),
      .func_word(applied_q),
      .pol_word(out_pol_q),
      .pin(output_pin[g])
    );
  end

  // ****************************************************************
  // Parameter port
  // ****************************************************************

  // Address decode and read mux; the input state word is RO.
  always_comb begin
    rd_data_d = '0;
    hit_d = 1'b0;
    ro_d = 1'b0;
    case (par_index)
      dio_pkg::IDX_IN_CFG: begin
        for (int k = 0; k < N_IN; k++) begin
          if (par_subindex == 8'(k + 1)) begin
            hit_d = 1'b1;
            rd_data_d = in_cfg_q[k];
          end
        end
      end
      dio_pkg::IDX_IN_FUNC: begin
        case (par_subindex)
          dio_pkg::SUB_STATE: begin
            hit_d = 1'b1;
            ro_d = 1'b1;
            rd_data_d = in_func_q & in_disp_q;
          end
          dio_pkg::SUB_MASK: begin
            hit_d = 1'b1;
            rd_data_d = in_disp_q;
          end
          dio_pkg::SUB_POL: begin
            hit_d = 1'b1;
            rd_data_d = in_pol_q;
          end
          dio_pkg::SUB_EXEC: begin
            hit_d = 1'b1;
            rd_data_d = in_exec_q;
          end
          default: begin
            hit_d = 1'b0;
          end
        endcase
      end
      dio_pkg::IDX_OUT_FUNC: begin
        case (par_subindex)
          dio_pkg::SUB_STATE: begin
            hit_d = 1'b1;
            rd_data_d = applied_q;
          end
          dio_pkg::SUB_MASK: begin
            hit_d = 1'b1;
            rd_data_d = out_mask_q;
          end
          dio_pkg::SUB_POL: begin
            hit_d = 1'b1;
            rd_data_d = out_pol_q;
          end
          default: begin
            hit_d = 1'b0;
          end
        endcase
      end
      dio_pkg::IDX_OUT_CFG: begin
        for (int k = 0; k < N_OUT; k++) begin
          if (par_subindex == 8'(k + 1)) begin
            hit_d = 1'b1;
            rd_data_d = out_cfg_q[k];
          end
        end
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  assign wr_ok = par_write & hit_d & ~ro_d;

  // Config entries; a value above 15 keeps only its low four bits as the selection.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < N_IN; k++) begin
        in_cfg_q[k] <= dio_pkg::CFG_TOP_RST - 16'(k);
      end
      for (int k = 0; k < N_OUT; k++) begin
        out_cfg_q[k] <= dio_pkg::CFG_TOP_RST - 16'(k);
      end
    end else if (wr_ok) begin
      for (int k = 0; k < N_IN; k++) begin
        if (par_index == dio_pkg::IDX_IN_CFG && par_subindex == 8'(k + 1)) begin
          in_cfg_q[k] <= par_wdata;
        end
      end
      for (int k = 0; k < N_OUT; k++) begin
        if (par_index == dio_pkg::IDX_OUT_CFG && par_subindex == 8'(k + 1)) begin
          out_cfg_q[k] <= par_wdata;
        end
      end
    end
  end

  // Mask, polarity and state words.
  always_ff @(posedge clk) begin
    if (reset) begin
      in_disp_q <= dio_pkg::IN_DISP_RST;
      in_pol_q <= dio_pkg::IN_POL_RST;
      in_exec_q <= dio_pkg::IN_EXEC_RST;
      out_state_q <= dio_pkg::OUT_STATE_RST;
      out_mask_q <= dio_pkg::OUT_MASK_RST;
      out_pol_q <= dio_pkg::OUT_POL_RST;
    end else if (wr_ok) begin
      if (par_index == dio_pkg::IDX_IN_FUNC) begin
        if (par_subindex == dio_pkg::SUB_MASK) in_disp_q <= par_wdata;
        if (par_subindex == dio_pkg::SUB_POL) in_pol_q <= par_wdata;
        if (par_subindex == dio_pkg::SUB_EXEC) in_exec_q <= par_wdata;
      end
      if (par_index == dio_pkg::IDX_OUT_FUNC) begin
        if (par_subindex == dio_pkg::SUB_STATE) out_state_q <= par_wdata;
        if (par_subindex == dio_pkg::SUB_MASK) out_mask_q <= par_wdata;
        if (par_subindex == dio_pkg::SUB_POL) out_pol_q <= par_wdata;
      end
    end
  end

  // Answer one cycle after each request; a write wins over a same-cycle read.
  always_ff @(posedge clk) begin
    if (reset) begin
      par_ack <= 1'b0;
      par_error <= 1'b0;
      par_rdata <= '0;
      rd_state_q <= 1'b0;
    end else begin
      par_ack <= par_write | par_read;
      par_error <= par_write ? ~wr_ok : (par_read & ~hit_d);
      par_rdata <= (par_read & ~par_write) ? rd_data_d : 16'h0000;
      rd_state_q <= par_read & ~par_write & ro_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_marker_rise;
    !in_func_q[dio_pkg::IN_MARKER] ##1 (in_func_q[dio_pkg::IN_MARKER] && in_exec_q[dio_pkg::IN_MARKER]);
  endsequence

  a_in_display_gate: assert property (par_ack && rd_state_q |-> (par_rdata & ~in_disp_q) == 16'h0000)
    else $error("input state read shows a bit the display mask hides");
  a_quick_stop_follow: assert property (in_func_q[dio_pkg::IN_QSTOP] && in_exec_q[dio_pkg::IN_QSTOP]
    |=> quick_stop)
    else $error("quick stop not requested");
  a_exec_gate_stop: assert property (!in_exec_q[dio_pkg::IN_QSTOP] |=> !quick_stop)
    else $error("quick stop acted while execution inhibited");
  a_home_switch_follow: assert property (home_switch == $past(in_func_q[dio_pkg::IN_HOME]
    && in_exec_q[dio_pkg::IN_HOME]))
    else $error("home switch does not follow its function");
  a_limit_error_raise: assert property (limit_error == (pos_limit || neg_limit))
    else $error("limit error disagrees with limit switches");
  a_marker_one_pulse: assert property (s_marker_rise |=> position_marker ##1 !position_marker)
    else $error("position marker is not a single pulse");
  a_input_pin_pol: assert property ((in_sync[0] ^ in_pol_q[in_cfg_q[0][SW-1:0]])
    |=> in_func_q[$past(in_cfg_q[0][SW-1:0])])
    else $error("active input pin does not set its function bit");
  a_brake_masked: assert property (out_mask_q[dio_pkg::OUT_BRAKE]
    |=> applied_q[dio_pkg::OUT_BRAKE] == $past(brake_engage))
    else $error("brake function not passed through enabled mask");
  a_out_mask_hold: assert property (!out_mask_q[15] |=> $stable(applied_q[15]))
    else $error("masked output function changed");
  a_unused_zero: assert property ((applied_q & ~dio_pkg::OUT_USED_BITS) == 16'h0000)
    else $error("unused output function bit is set");
  a_out_pin_pol: assert property (##1 output_pin[0] == $past(applied_q[out_cfg_q[0][SW-1:0]]
    ^ out_pol_q[out_cfg_q[0][SW-1:0]]))
    else $error("output pin polarity wrong");
  a_ack_next_cycle: assert property ((par_write || par_read) |=> par_ack)
    else $error("parameter request not answered in the next cycle");
  a_ready_source: assert property (out_mask_q[dio_pkg::OUT_READY]
    |=> applied_q[dio_pkg::OUT_READY] == $past(device_ready && !device_fault))
    else $error("ready function does not follow ready and fault");
  a_compare_source: assert property (out_mask_q[dio_pkg::OUT_PCMP]
    |=> applied_q[dio_pkg::OUT_PCMP] == $past(compare_trigger))
    else $error("compare function does not follow the trigger");

endmodule : dio_function_mapper

`default_nettype wire

// ==== dio_pkg.sv ====
/*
 * Constants shared by the digital I/O function mapper: parameter index and
 * sub-index codes, function bit positions, field widths and reset values.
 * Assumes a single clock domain; the parameter port is driven by a
 * same-clock command decoder that carries fieldbus or serial requests.
 */
// Operation
// - Input pin config value picks which function state bit the pin drives.
// - Input function bit 5 active requests the quick-stop profile.
// - Input function bit 2 is the home switch for homing.
// - Bits 1 and 0 are positive/negative limits, raising limit error.
// - Input polarity 0 means pin active high, 1 active low.
// - Input state bits are read back only where display mask enables.
// - Each input function state enables or disables its own action.
// - Readable input function state word reports each configured function its display mask enables.
// - Output config value picks which output function bit drives the pin.
// - Five output config entries, one function selection per output pin.
// - Output function state word is writable to set digital outputs.
// - Per-bit output mask filters which functions reach the pins.
// - State change reaches the pin only where the output mask enables.
// - Output function bit 2 drives the holding brake; active engages it.
// - Output function bit 1 carries the position compare trigger.
// - Output function bit 0 is active while ready, inactive on fault.
// - Output polarity 0 drives logic 1 high; polarity 1 inverts.

package dio_pkg;

  // ****************************************************************
  // Parameter addresses
  // ****************************************************************
  localparam logic [15:0] IDX_IN_CFG = 16'h2070;
  localparam logic [15:0] IDX_IN_FUNC = 16'h2071;
  localparam logic [15:0] IDX_OUT_FUNC = 16'h2078;
  localparam logic [15:0] IDX_OUT_CFG = 16'h2079;
  localparam logic [7:0] SUB_STATE = 8'h01;
  localparam logic [7:0] SUB_MASK = 8'h02;
  localparam logic [7:0] SUB_POL = 8'h03;
  localparam logic [7:0] SUB_EXEC = 8'h04;

  // ****************************************************************
  // Function bit positions and field widths
  // ****************************************************************
  localparam int SEL_W = 4;
  localparam int IN_NEG_LIMIT = 0;
  localparam int IN_POS_LIMIT = 1;
  localparam int IN_HOME = 2;
  localparam int IN_MARKER = 3;
  localparam int IN_ENABLE = 4;
  localparam int IN_QSTOP = 5;
  localparam int OUT_READY = 0;
  localparam int OUT_PCMP = 1;
  localparam int OUT_BRAKE = 2;
  localparam logic [15:0] OUT_GP_BITS = 16'hf800;
  localparam logic [15:0] OUT_USED_BITS = 16'hf807;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] CFG_TOP_RST = 16'h000f;
  localparam logic [15:0] IN_DISP_RST = 16'hffff;
  localparam logic [15:0] IN_POL_RST = 16'h0000;
  localparam logic [15:0] IN_EXEC_RST = 16'hffff;
  localparam logic [15:0] OUT_STATE_RST = 16'h0000;
  localparam logic [15:0] OUT_MASK_RST = 16'hffff;
  localparam logic [15:0] OUT_POL_RST = 16'h0000;

endpackage : dio_pkg

// ==== dio_sync2.sv ====
/*
 * Two-flop synchroniser for a bus of independent pin levels.
 * Assumes each bit is a slow level; no bus coherency is implied.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : dio_sync2

`default_nettype wire

// ==== dio_out_map.sv ====
/*
 * One output pin: picks its function bit and applies that bit's polarity.
 * Assumes the function word has already passed the output mask.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_out_map (
  input wire logic clk,
  input wire logic reset,
  input wire logic [dio_pkg::SEL_W-1:0] sel,
  input wire logic [15:0] func_word,
  input wire logic [15:0] pol_word,
  output var logic pin
);

  // Polarity comes last, right before the pin register.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin <= 1'b0;
    end else begin
      pin <= func_word[sel] ^ pol_word[sel];
    end
  end

endmodule : dio_out_map

`default_nettype wire

// ==== dio_pin_model.sv ====
/*
 * Pin-side partner: switches and sensors on the input pins, loads on the
 * output pins. Assumes it shares clk with the mapper under test.
 */
`timescale 1ns/1ns
`default_nettype none

module dio_pin_model (
  input wire logic clk,
  input wire logic [9:0] switch_req,
  input wire logic [4:0] output_pin,
  output var logic [9:0] input_pin,
  output var logic [4:0] load_on
);
  // ****************************************************************
  // Switches move only on the falling edge, away from sampling.
  // ****************************************************************
  initial begin
    input_pin = 10'h000;
  end

  // A real contact changes at any time; the falling edge keeps this one race free.
  always @(negedge clk) begin
    input_pin <= switch_req;
  end

  // Loads simply follow their pin level.
  assign load_on = output_pin;
endmodule : dio_pin_model
`default_nettype wire

// ==== tb_dio_function_mapper.sv ====
/*
 * Self-checking bench for the digital I/O function mapper.
 * Assumes the one-cycle strobe parameter port and the pin model beside it.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_dio_function_mapper;
  logic clk, reset, par_write, par_read, par_ack, par_error;
  logic [15:0] par_index, par_wdata, par_rdata, got, rv;
  logic [7:0] par_subindex;
  logic [9:0] switch_req, input_pin;
  logic [4:0] output_pin, load_on;
  logic brake_engage, compare_trigger, device_ready, device_fault;
  logic quick_stop, device_enable, position_marker, home_switch;
  logic pos_limit, neg_limit, limit_error, mark_seen, er;
  int n_mismatch, cmp_count;

  // ****************************************************************
  // Clock, partner and design
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dio_pin_model i_dio_pin_model (.clk(clk), .switch_req(switch_req), .output_pin(output_pin),
    .input_pin(input_pin), .load_on(load_on));

  dio_function_mapper i_dio_function_mapper (.clk(clk), .reset(reset), .par_index(par_index),
    .par_subindex(par_subindex), .par_write(par_write), .par_read(par_read), .par_wdata(par_wdata),
    .par_rdata(par_rdata), .par_ack(par_ack), .par_error(par_error), .input_pin(input_pin),
    .output_pin(output_pin), .brake_engage(brake_engage), .compare_trigger(compare_trigger),
    .device_ready(device_ready), .device_fault(device_fault), .quick_stop(quick_stop),
    .device_enable(device_enable), .position_marker(position_marker), .home_switch(home_switch),
    .pos_limit(pos_limit), .neg_limit(neg_limit), .limit_error(limit_error));

  // The marker is a one-cycle pulse, so it is latched to be seen later.
  always @(posedge clk) begin
    if (position_marker === 1'b1) begin
      mark_seen <= 1'b1;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One strobe cycle, then a bounded wait for the acknowledge.
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [15:0] d);
    par_write = wr;
    par_read = ~wr;
    par_index = idx;
    par_subindex = sub;
    par_wdata = d;
    @(negedge clk);
    par_write = 1'b0;
    par_read = 1'b0;
    er = 1'bx;
    for (int k = 0; k < 4; k++) begin
      if (par_ack === 1'b1) begin
        rv = par_rdata;
        er = par_error;
        break;
      end
      @(negedge clk);
    end
    // One idle cycle keeps the strobe of the next call apart from this lowering.
    @(negedge clk);
    chk("ack", 16'h0001, {15'h0, er !== 1'bx});
  endtask : acc

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] d);
    acc(1'b1, idx, sub, d);
    chk("write error", 16'h0000, {15'h0, er});
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] exp);
    acc(1'b0, idx, sub, 16'h0000);
    chk("read error", 16'h0000, {15'h0, er});
    chk("read data", exp, rv);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    reset = 1'b1;
    par_write = 1'b0;
    par_read = 1'b0;
    par_index = 16'h0000;
    par_subindex = 8'h00;
    par_wdata = 16'h0000;
    switch_req = 10'h000;
    brake_engage = 1'b0;
    compare_trigger = 1'b0;
    device_ready = 1'b0;
    device_fault = 1'b0;
    mark_seen = 1'b0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    rd(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_MASK, 16'hffff);
    rd(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_MASK, 16'hffff);
    rd(dio_pkg::IDX_OUT_CFG, 8'h05, 16'h000b);
    acc(1'b0, 16'h2000, 8'h01, 16'h0000);
    chk("unmapped error", 16'h0001, {15'h0, er});
    acc(1'b1, dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_STATE, 16'hffff);
    chk("read-only error", 16'h0001, {15'h0, er});
    // Each special input function in turn on the first pin.
    for (int v = 0; v < 6; v++) begin
      switch_req = 10'h000;
      wr(dio_pkg::IDX_IN_CFG, 8'h01, 16'(v));
      settle(8);
      mark_seen = 1'b0;
      switch_req = 10'h001;
      settle(8);
      got = {9'h0, limit_error, quick_stop, device_enable, mark_seen, home_switch, pos_limit, neg_limit};
      chk("actions", (16'h1 << v) | ((v < 2) ? 16'h0040 : 16'h0000), got);
      rd(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_STATE, 16'h1 << v);
    end
    wr(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_MASK, 16'hffdf);
    rd(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_STATE, 16'h0000);
    wr(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_EXEC, 16'hffdf);
    settle(4);
    chk("exec masked", 16'h0000, {15'h0, quick_stop});
    wr(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_POL, 16'h0020);
    wr(dio_pkg::IDX_IN_FUNC, dio_pkg::SUB_EXEC, 16'hffff);
    settle(8);
    chk("active low", 16'h0000, {15'h0, quick_stop});
    switch_req = 10'h000;
    settle(8);
    chk("active low", 16'h0001, {15'h0, quick_stop});
    // Outputs: brake, compare, ready, one general purpose, one idle.
    wr(dio_pkg::IDX_OUT_CFG, 8'h01, 16'h0002);
    wr(dio_pkg::IDX_OUT_CFG, 8'h02, 16'h0001);
    wr(dio_pkg::IDX_OUT_CFG, 8'h03, 16'h0000);
    wr(dio_pkg::IDX_OUT_CFG, 8'h04, 16'h000b);
    wr(dio_pkg::IDX_OUT_CFG, 8'h05, 16'h000f);
    rd(dio_pkg::IDX_OUT_CFG, 8'h04, 16'h000b);
    brake_engage = 1'b1;
    compare_trigger = 1'b1;
    device_ready = 1'b1;
    wr(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_STATE, 16'h0800);
    settle(6);
    chk("pins", 16'h000f, {11'h0, load_on});
    rd(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_STATE, 16'h0807);
    device_fault = 1'b1;
    settle(6);
    chk("pins", 16'h000b, {11'h0, load_on});
    wr(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_MASK, 16'h7ffb);
    brake_engage = 1'b0;
    settle(6);
    chk("pins", 16'h000b, {11'h0, load_on});
    wr(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_MASK, 16'hffff);
    settle(6);
    chk("pins", 16'h000a, {11'h0, load_on});
    wr(dio_pkg::IDX_OUT_FUNC, dio_pkg::SUB_POL, 16'h8000);
    settle(6);
    chk("pins", 16'h001a, {11'h0, load_on});
    // The compare pin must also fall, not merely rise.
    compare_trigger = 1'b0;
    settle(6);
    chk("pins", 16'h0018, {11'h0, load_on});
    give_verdict();
  end
endmodule : tb_dio_function_mapper
`default_nettype wire
